// [pkg/memory_map_lock_access_guard_consts.svh]
// Address map, lock key and timing constants for the access guard.
// Assumes inclusion by its bare name from the design files.
`ifndef MEMORY_MAP_LOCK_ACCESS_GUARD_CONSTS_SVH
`define MEMORY_MAP_LOCK_ACCESS_GUARD_CONSTS_SVH
`define IO_BASE 16'h0000
`define IO_END 16'h107F
`define IDROW_BASE 16'h1100
`define IDROW_END 16'h11FF
`define FUSE_BASE 16'h1280
`define FUSE_END 16'h1289
`define LOCK_KEY_ADDR 16'h128A
`define USER_PAGE_BASE 16'h1300
`define USER_PAGE_END 16'h137F
`define EEPROM_BASE 16'h1400
`define EEPROM_BYTES 16'h0080
`define EEPROM_PAGE_BYTES 16'h0020
`define EEPROM_PAGES 4
`define SRAM_BASE_SMALL 16'h3E00
`define SRAM_BYTES_SMALL 16'h0200
`define SRAM_BASE_LARGE 16'h3C00
`define SRAM_BYTES_LARGE 16'h0400
`define FLASH_DATA_BASE 16'h8000
`define FLASH_CODE_BASE 16'h0000
`define FLASH_PAGE_BYTES 64
`define FLASH_PAGES_SMALL 64
`define FLASH_PAGES_LARGE 128
`define LOCK_KEY_OPEN 8'hC5
`define LOCK_KEY_RESET 8'h00
`define WRITE_BLOCK_SLOW_CYCLES 768
`endif

// [pkg/memory_map_lock_access_guard_pkg.sv]
// Types shared by the access guard design files.
// Assumes the constants header sits on the include path.
package memory_map_lock_access_guard_pkg;
  typedef enum logic [3:0] {
    region_none,
    region_io,
    region_id_row,
    region_fuse,
    region_lock,
    region_user_page,
    region_eeprom,
    region_sram,
    region_flash
  } region_e;
  typedef enum logic [1:0] {
    flash_boot,
    flash_app_code,
    flash_app_data
  } flash_section_e;
endpackage

// [testbench/guard_memory_model.sv]
// Memory stand-in on the routed side of the guard.
// Assumes mem_req and mem_offset settle combinationally within the cycle.
`timescale 1ns/1ps
module guard_memory_model
(
  // Clock.
  input wire logic sys_clk,
  // Routed strobe.
  input wire logic mem_req,
  input wire logic [15:0] mem_offset,
  // Read data.
  output logic [7:0] mem_rdata
);
  logic [7:0] noise = 8'h00;
  // An unselected memory shows a changing pattern so stale data never matches.
  always @(posedge sys_clk) noise <= noise + 8'h3B;
  assign mem_rdata = mem_req ? (mem_offset[7:0] ^ 8'h5A) : noise;
endmodule

// [testbench/memory_map_lock_access_guard_asserts.sv]
// Port-level checker of routing and lock decisions of the guard.
// Assumes it is bound to the guard top and sees only its ports.
`timescale 1ns/1ps
module guard_checker
import memory_map_lock_access_guard_pkg::*;
#(
  parameter int WRITE_BLOCK_TICKS = 768
)
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Requests.
  input wire logic large_variant,
  input wire logic startup_done,
  input wire logic [7:0] stored_lock_key,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [15:0] cpu_addr,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic dbg_req,
  input wire logic dbg_we,
  input wire logic dbg_fuse_write,
  input wire logic [15:0] dbg_addr,
  input wire logic full_erase_command,
  // Answers.
  input wire logic mem_req,
  input memory_map_lock_access_guard_pkg::region_e mem_region,
  input wire logic [15:0] mem_offset,
  input wire logic erase_app_memories,
  input wire logic cpu_refused,
  input wire logic [7:0] dbg_rdata,
  input wire logic dbg_done,
  input wire logic dbg_refused,
  input wire logic fetch_fault,
  input wire logic locked
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire [15:0] sram_base = large_variant ? 16'h3C00 : 16'h3E00;
  wire dbg_only = dbg_req && !cpu_req;
  wire user_fw = dbg_we && dbg_fuse_write && dbg_addr inside {[16'h1300:16'h137F]};
  a_flash_data_route:
  assert property (cpu_req && !cpu_we && cpu_addr >= 16'h8000
    |-> mem_region == region_flash && mem_offset == cpu_addr - 16'h8000)
    else $error("flash data route wrong");
  a_sram_window_route:
  assert property (cpu_req && !cpu_we && cpu_addr >= sram_base && cpu_addr <= 16'h3FFF
    |-> mem_region == region_sram && mem_offset == cpu_addr - sram_base)
    else $error("sram route wrong");
  a_lock_key_decision:
  assert property (startup_done |=> locked == ($past(stored_lock_key) != 8'hC5))
    else $error("lock decision wrong");
  a_locked_dbg_refused:
  assert property (locked && dbg_only && !full_erase_command && !user_fw
    |=> dbg_done && dbg_refused && dbg_rdata == 8'h00)
    else $error("locked debug access not refused");
  a_user_page_write:
  assert property (locked && dbg_only && user_fw
    |-> mem_req && mem_region == region_user_page ##1 !dbg_refused)
    else $error("locked user page write not passed");
  a_cpu_fuse_refused:
  assert property (cpu_req && cpu_we && cpu_addr inside {[16'h1280:16'h128A]} |=> cpu_refused)
    else $error("cpu fuse write not refused");
  a_id_row_ro:
  assert property (!locked && dbg_only && dbg_we && dbg_addr inside {[16'h1100:16'h11FF]}
    |=> dbg_refused)
    else $error("id row write not refused");
  a_fetch_bound_fault:
  assert property (fetch_req && fetch_addr >= (large_variant ? 16'h1000 : 16'h0800)
    |=> fetch_fault)
    else $error("fetch outside flash not faulted");
  a_erase_pulse_once:
  assert property (full_erase_command |=> erase_app_memories ##1 !erase_app_memories)
    else $error("erase pulse wrong");
endmodule
bind memory_map_lock_access_guard guard_checker #(.WRITE_BLOCK_TICKS(WRITE_BLOCK_TICKS)) chk_i
(
  .sys_clk(sys_clk), .rst(rst), .large_variant(large_variant), .startup_done(startup_done),
  .stored_lock_key(stored_lock_key), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
  .fetch_req(fetch_req), .fetch_addr(fetch_addr), .dbg_req(dbg_req), .dbg_we(dbg_we),
  .dbg_fuse_write(dbg_fuse_write), .dbg_addr(dbg_addr), .full_erase_command(full_erase_command),
  .mem_req(mem_req), .mem_region(mem_region), .mem_offset(mem_offset),
  .erase_app_memories(erase_app_memories), .cpu_refused(cpu_refused), .dbg_rdata(dbg_rdata),
  .dbg_done(dbg_done), .dbg_refused(dbg_refused), .fetch_fault(fetch_fault), .locked(locked)
);

// [testbench/memory_map_lock_access_guard_tb.sv]
// Self-checking bench: CPU, debug and code-side access sequences on the guard.
// Assumes the package, design, memory model and checker are compiled first.
`timescale 1ns/1ps
module memory_map_lock_access_guard_tb;
  import memory_map_lock_access_guard_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, large_variant = 1'b0, power_on = 1'b0;
  logic slow_tick = 1'b0, startup_done = 1'b0, startup_write_block_disable = 1'b1;
  logic cpu_req = 1'b0, cpu_we = 1'b0, fetch_req = 1'b0, pmr_req = 1'b0, dbg_req = 1'b0;
  logic dbg_we = 1'b0, dbg_fuse_write = 1'b0, full_erase_command = 1'b0;
  logic [7:0] stored_lock_key = 8'h00, cpu_wdata = 8'h00, dbg_wdata = 8'h00;
  logic [15:0] cpu_addr = 16'h0, fetch_addr = 16'h0, pmr_addr = 16'h0, dbg_addr = 16'h0;
  logic mem_req, mem_we, flash_code_req, erase_app_memories, cpu_refused, dbg_done;
  logic dbg_refused, fetch_fault, locked, nv_write_blocked;
  logic [15:0] mem_offset, flash_code_word, seen_offset;
  logic [7:0] mem_wdata, mem_rdata, cpu_rdata, dbg_rdata, lock_key_byte;
  region_e mem_region, seen_region;
  int bad_count = 0, num_checks = 0, cycles = 0;
  localparam logic [15:0] TAB_A [7] = '{16'h8000, 16'h8FFF, 16'h3E00, 16'h3FFF, 16'h1400,
    16'h147F, 16'h1300};
  localparam logic [15:0] TAB_O [7] = '{16'h0, 16'h0FFF, 16'h0, 16'h01FF, 16'h0, 16'h007F, 16'h0};
  localparam region_e TAB_R [7] = '{region_flash, region_flash, region_sram, region_sram,
    region_eeprom, region_eeprom, region_user_page};
  memory_map_lock_access_guard #(.WRITE_BLOCK_TICKS(4)) DUT
  (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .large_variant(large_variant),
    .power_on(power_on), .slow_tick(slow_tick), .startup_done(startup_done),
    .stored_lock_key(stored_lock_key), .startup_write_block_disable(startup_write_block_disable),
    .boot_end_page(8'h00), .app_end_page(8'h00), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_pc(16'h0000), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .pmr_req(pmr_req), .pmr_addr(pmr_addr), .dbg_req(dbg_req),
    .dbg_we(dbg_we), .dbg_fuse_write(dbg_fuse_write), .dbg_addr(dbg_addr),
    .dbg_wdata(dbg_wdata), .full_erase_command(full_erase_command), .mem_req(mem_req),
    .mem_we(mem_we), .mem_region(mem_region), .mem_offset(mem_offset), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .flash_code_req(flash_code_req), .flash_code_word(flash_code_word),
    .erase_app_memories(erase_app_memories), .cpu_rdata(cpu_rdata), .cpu_refused(cpu_refused),
    .dbg_rdata(dbg_rdata), .dbg_done(dbg_done), .dbg_refused(dbg_refused),
    .fetch_fault(fetch_fault), .locked(locked), .lock_key_byte(lock_key_byte),
    .nv_write_blocked(nv_write_blocked)
  );
  guard_memory_model mem_model
  (
    .sys_clk(sys_clk), .mem_req(mem_req), .mem_offset(mem_offset), .mem_rdata(mem_rdata)
  );
  initial forever #4 sys_clk = ~sys_clk;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // The ceiling sits well above the hundred or so cycles the tests need.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic boot(input logic [7:0] key);
    rst = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 rst = 1'b0;
    stored_lock_key = key;
    startup_done = 1'b1;
    @(posedge sys_clk);
    #1 startup_done = 1'b0;
  endtask
  // One request held for one edge; registered answers are read as it ends.
  task automatic acc(input logic d, input logic we, input logic fw, input logic [15:0] addr);
    @(posedge sys_clk);
    #1 cpu_req = !d;
    dbg_req = d;
    cpu_we = we;
    dbg_we = we;
    dbg_fuse_write = fw;
    cpu_addr = addr;
    dbg_addr = addr;
    cpu_wdata = addr[7:0];
    dbg_wdata = 8'hFF;
    #1 seen_region = mem_region;
    seen_offset = mem_offset;
    @(posedge sys_clk);
    #1 cpu_req = 1'b0;
    dbg_req = 1'b0;
  endtask
  task automatic code(input logic p, input logic [15:0] addr);
    @(posedge sys_clk);
    #1 fetch_req = !p;
    pmr_req = p;
    fetch_addr = addr;
    pmr_addr = addr;
    #1 seen_offset = flash_code_word;
    @(posedge sys_clk);
    #1 fetch_req = 1'b0;
    pmr_req = 1'b0;
  endtask
  initial
  begin
    boot(8'h00);
    chk(locked, 1'b1);
    chk(lock_key_byte, 8'h00);
    acc(1'b1, 1'b0, 1'b0, 16'h3E10);
    chk(dbg_refused, 1'b1);
    chk(dbg_done, 1'b1);
    chk(dbg_rdata, 8'h00);
    acc(1'b1, 1'b1, 1'b1, 16'h1305);
    chk(seen_region, region_user_page);
    chk(dbg_refused, 1'b0);
    acc(1'b1, 1'b0, 1'b0, 16'h1305);
    chk(dbg_refused, 1'b1);
    acc(1'b0, 1'b0, 1'b0, 16'h1410);
    chk(cpu_rdata, 8'h10 ^ 8'h5A);
    @(posedge sys_clk);
    #1 full_erase_command = 1'b1;
    @(posedge sys_clk);
    #1 full_erase_command = 1'b0;
    chk(erase_app_memories, 1'b1);
    repeat (4) @(posedge sys_clk);
    #1 chk(locked, 1'b0);
    acc(1'b1, 1'b0, 1'b0, 16'h3E10);
    chk(dbg_refused, 1'b0);
    $display("test locked done");
    boot(8'hC5);
    chk(locked, 1'b0);
    stored_lock_key = 8'h3A;
    repeat (3) @(posedge sys_clk);
    #1 chk(locked, 1'b0);
    chk(lock_key_byte, 8'hC5);
    foreach (TAB_A[i])
    begin
      acc(1'b0, 1'b0, 1'b0, TAB_A[i]);
      chk(seen_region, TAB_R[i]);
      chk(seen_offset, TAB_O[i]);
      chk(cpu_rdata, TAB_O[i][7:0] ^ 8'h5A);
    end
    acc(1'b1, 1'b0, 1'b0, 16'h1310);
    chk(dbg_refused, 1'b0);
    acc(1'b1, 1'b1, 1'b0, 16'h1100);
    chk(dbg_refused, 1'b1);
    acc(1'b1, 1'b1, 1'b1, 16'h1280);
    chk(dbg_refused, 1'b0);
    acc(1'b0, 1'b1, 1'b0, 16'h128A);
    chk(cpu_refused, 1'b1);
    acc(1'b0, 1'b0, 1'b0, 16'h1284);
    chk(cpu_refused, 1'b0);
    code(1'b1, 16'h0021);
    chk(seen_offset, 16'h0010);
    code(1'b0, 16'h07FF);
    chk(fetch_fault, 1'b0);
    code(1'b0, 16'h0800);
    chk(fetch_fault, 1'b1);
    $display("test open done");
    large_variant = 1'b1;
    boot(8'hC5);
    acc(1'b0, 1'b0, 1'b0, 16'h3C00);
    chk(seen_region, region_sram);
    code(1'b0, 16'h0FFF);
    chk(fetch_fault, 1'b0);
    startup_write_block_disable = 1'b0;
    boot(8'hC5);
    #8 power_on = 1'b1;
    #8 power_on = 1'b0;
    chk(nv_write_blocked, 1'b1);
    acc(1'b0, 1'b1, 1'b0, 16'h1400);
    chk(cpu_refused, 1'b1);
    repeat (5)
    begin
      #8 slow_tick = 1'b1;
      #8 slow_tick = 1'b0;
    end
    chk(nv_write_blocked, 1'b0);
    acc(1'b0, 1'b1, 1'b0, 16'h1400);
    chk(cpu_refused, 1'b0);
    $display("test write block done");
    print_verdict();
  end
endmodule

// [verilog/address_region_decoder.sv]
// Decodes one data-space address into a region and a region-local offset.
// Assumes the variant select is static while the device runs.
`timescale 1ns/1ps
`include "memory_map_lock_access_guard_consts.svh"
module address_region_decoder
(
  // Request address.
  input wire logic [15:0] addr,
  input wire logic large_variant,
  // Decode result.
  output memory_map_lock_access_guard_pkg::region_e region,
  output logic [15:0] offset
);
  import memory_map_lock_access_guard_pkg::*;
  wire [15:0] sram_base = large_variant ? `SRAM_BASE_LARGE : `SRAM_BASE_SMALL;
  wire [15:0] sram_size = large_variant ? `SRAM_BYTES_LARGE : `SRAM_BYTES_SMALL;
  wire [15:0] flash_size = large_variant ? 16'h2000 : 16'h1000;
  wire in_io = addr <= `IO_END;
  wire in_id = addr >= `IDROW_BASE && addr <= `IDROW_END;
  wire in_fuse = addr >= `FUSE_BASE && addr <= `FUSE_END;
  wire in_lock = addr == `LOCK_KEY_ADDR;
  wire in_user = addr >= `USER_PAGE_BASE && addr <= `USER_PAGE_END;
  wire in_ee = addr >= `EEPROM_BASE && addr < `EEPROM_BASE + `EEPROM_BYTES;
  wire in_sram = addr >= sram_base && addr < sram_base + sram_size;
  wire in_flash = addr >= `FLASH_DATA_BASE && addr < `FLASH_DATA_BASE + flash_size;
  always_comb
  begin
    region = region_none;
    offset = 16'h0000;
    if (in_io)
    begin
      region = region_io;
      offset = addr;
    end
    else if (in_id)
    begin
      region = region_id_row;
      offset = addr - `IDROW_BASE;
    end
    else if (in_fuse)
    begin
      region = region_fuse;
      offset = addr - `FUSE_BASE;
    end
    else if (in_lock)
    begin
      region = region_lock;
      offset = 16'h0000;
    end
    else if (in_user)
    begin
      region = region_user_page;
      offset = addr - `USER_PAGE_BASE;
    end
    else if (in_ee)
    begin
      region = region_eeprom;
      offset = addr - `EEPROM_BASE;
    end
    else if (in_sram)
    begin
      region = region_sram;
      offset = addr - sram_base;
    end
    else if (in_flash)
    begin
      region = region_flash;
      offset = addr - `FLASH_DATA_BASE;
    end
  end
endmodule

// [verilog/memory_map_lock_access_guard.sv]
// Top of the memory map decoder and lock-based access guard for CPU and debug requesters.
// Assumes memories sit outside and answer the routed strobes in the same cycle.
`timescale 1ns/1ps
`include "memory_map_lock_access_guard_consts.svh"
module memory_map_lock_access_guard
#(
  parameter int FLASH_PAGE_BYTES = `FLASH_PAGE_BYTES,
  parameter int WRITE_BLOCK_TICKS = `WRITE_BLOCK_SLOW_CYCLES
)
(
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Static configuration, power-on pulse and slow tick.
  input wire logic large_variant,
  input wire logic power_on,
  input wire logic slow_tick,
  // Start-up fuse image.
  input wire logic startup_done,
  input wire logic [7:0] stored_lock_key,
  input wire logic startup_write_block_disable,
  input wire logic [7:0] boot_end_page,
  input wire logic [7:0] app_end_page,
  // CPU data request.
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [15:0] cpu_pc,
  // CPU instruction and program memory read.
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic pmr_req,
  input wire logic [15:0] pmr_addr,
  // Debug request.
  input wire logic dbg_req,
  input wire logic dbg_we,
  input wire logic dbg_fuse_write,
  input wire logic [15:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  input wire logic full_erase_command,
  // Memory side.
  output logic mem_req,
  output logic mem_we,
  output memory_map_lock_access_guard_pkg::region_e mem_region,
  output logic [15:0] mem_offset,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic flash_code_req,
  output logic [15:0] flash_code_word,
  output logic erase_app_memories,
  // Answers.
  output logic [7:0] cpu_rdata,
  output logic cpu_refused,
  output logic [7:0] dbg_rdata,
  output logic dbg_done,
  output logic dbg_refused,
  output logic fetch_fault,
  output logic locked,
  output logic [7:0] lock_key_byte,
  output logic nv_write_blocked
);
  import memory_map_lock_access_guard_pkg::*;
  region_e cpu_region;
  region_e dbg_region;
  logic [15:0] cpu_off;
  logic [15:0] dbg_off;
  logic erase_pending;
  address_region_decoder cpu_dec
  (
    .addr(cpu_addr),
    .large_variant(large_variant),
    .region(cpu_region),
    .offset(cpu_off)
  );
  address_region_decoder dbg_dec
  (
    .addr(dbg_addr),
    .large_variant(large_variant),
    .region(dbg_region),
    .offset(dbg_off)
  );
  write_block_timer #(.TICKS(WRITE_BLOCK_TICKS)) wb_timer
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .start(power_on),
    .disable_block(startup_write_block_disable),
    .slow_tick(slow_tick),
    .blocking(nv_write_blocked)
  );
  // Lock key is taken only once per start-up, so fuse writes act after reset.
  logic [7:0] latched_key;
  logic [7:0] boot_end;
  logic [7:0] app_end;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      latched_key <= `LOCK_KEY_RESET;
      boot_end <= 8'h00;
      app_end <= 8'h00;
    end
    else if (clk_en && startup_done)
    begin
      latched_key <= stored_lock_key;
      boot_end <= boot_end_page;
      app_end <= app_end_page;
    end
  end
  // Reset value reads locked until start-up copies the key, the safe default.
  wire is_locked = latched_key != `LOCK_KEY_OPEN;
  // Flash sections from page bounds; byte offset over page size gives page index.
  function automatic flash_section_e section_of(input logic [15:0] off);
    logic [15:0] page;
    page = off / 16'(FLASH_PAGE_BYTES);
    if (page < {8'h00, boot_end})
      section_of = flash_boot;
    else if (page < {8'h00, app_end})
      section_of = flash_app_code;
    else
      section_of = flash_app_data;
  endfunction
  wire [15:0] pc_byte = {cpu_pc[14:0], 1'b0};
  wire flash_section_block = cpu_region == region_flash &&
    section_of(cpu_off) < section_of(pc_byte);
  wire nv_region = cpu_region == region_flash || cpu_region == region_eeprom ||
    cpu_region == region_user_page;
  // CPU write refusals: identification row, fuses, lock, section and timeout blocks.
  wire cpu_wr_refuse = cpu_we && (cpu_region == region_id_row ||
    cpu_region == region_fuse || cpu_region == region_lock ||
    flash_section_block || (nv_region && nv_write_blocked));
  wire cpu_ok = cpu_req && !cpu_wr_refuse && cpu_region != region_none;
  // Debug permissions; when locked only user page writes through fuse write pass.
  wire dbg_user_locked_wr = dbg_we && dbg_fuse_write && dbg_region == region_user_page;
  wire dbg_id_wr = dbg_we && dbg_region == region_id_row;
  wire dbg_locked_ok = dbg_user_locked_wr;
  wire dbg_open_ok = !dbg_id_wr && dbg_region != region_none;
  wire dbg_nv_blk = dbg_we && nv_write_blocked && dbg_region != region_io;
  // The erase-cleared lock must open the debug path too, not only the status output.
  wire dbg_allow = (locked ? dbg_locked_ok : dbg_open_ok) && !dbg_nv_blk;
  // CPU wins the shared port; debug is not served in any cycle the CPU asks.
  wire dbg_go = dbg_req && !cpu_req && !erase_pending;
  wire dbg_ok = dbg_go && dbg_allow;
  assign mem_req = cpu_ok || dbg_ok;
  assign mem_we = cpu_ok ? cpu_we : dbg_we;
  assign mem_region = cpu_ok ? cpu_region : (dbg_ok ? dbg_region : region_none);
  assign mem_offset = cpu_ok ? cpu_off : dbg_off;
  assign mem_wdata = cpu_ok ? cpu_wdata : dbg_wdata;
  // Byte-wide accesses let EEPROM take single bytes or bursts of back-to-back ones.
  wire ee_burst_ok = 1'b1;
  // Fetch only from Flash code space; a data-space SRAM address never fetches.
  wire [15:0] code_limit = large_variant ? 16'h1000 : 16'h0800;
  wire fetch_in_flash = fetch_addr < code_limit;
  wire [15:0] pmr_word = {1'b0, pmr_addr[15:1]};
  assign flash_code_req = (fetch_req && fetch_in_flash) || (pmr_req && !fetch_req);
  assign flash_code_word = fetch_req ? fetch_addr : (pmr_word - `FLASH_CODE_BASE);
  // Erase: sole way out of locked state; user page left alone by memories.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      erase_pending <= 1'b0;
    else if (clk_en)
      erase_pending <= full_erase_command && !erase_pending;
  end
  assign erase_app_memories = erase_pending;
  logic erase_unlock;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      erase_unlock <= 1'b0;
    else if (clk_en && erase_pending)
      erase_unlock <= 1'b1;
  end
  assign locked = is_locked && !erase_unlock;
  // Answers registered one cycle after the request.
  logic cpu_read_q;
  logic dbg_read_q;
  logic dbg_refused_q;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cpu_rdata <= 8'h00;
      dbg_rdata <= 8'h00;
      cpu_refused <= 1'b0;
      dbg_refused <= 1'b0;
      dbg_done <= 1'b0;
      fetch_fault <= 1'b0;
      lock_key_byte <= `LOCK_KEY_RESET;
    end
    else if (clk_en)
    begin
      cpu_refused <= cpu_req && !cpu_ok;
      dbg_done <= dbg_go;
      dbg_refused <= dbg_go && !dbg_allow;
      fetch_fault <= fetch_req && !fetch_in_flash;
      lock_key_byte <= latched_key;
      if (cpu_ok && !cpu_we && ee_burst_ok)
        cpu_rdata <= mem_rdata;
      if (dbg_go && !dbg_we)
        dbg_rdata <= dbg_ok ? mem_rdata : 8'h00;
    end
  end
endmodule

// [verilog/write_block_timer.sv]
// Counts slow-oscillator ticks after power-on and blocks nonvolatile writes until done.
// Assumes slow_tick is a one-cycle pulse already in the system clock domain.
`timescale 1ns/1ps
`include "memory_map_lock_access_guard_consts.svh"
module write_block_timer
#(
  parameter int TICKS = `WRITE_BLOCK_SLOW_CYCLES
)
(
  // Clock and control.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic disable_block,
  input wire logic slow_tick,
  // Status.
  output logic blocking
);
  logic [15:0] count;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      count <= 16'h0000;
      blocking <= 1'b0;
    end
    else if (clk_en)
    begin
      if (start)
      begin
        count <= 16'h0000;
        blocking <= !disable_block;
      end
      else if (blocking && slow_tick)
      begin
        count <= count + 16'h0001;
        if (count == 16'(TICKS - 1))
          blocking <= 1'b0;
      end
    end
  end
endmodule
